// ===== eesr_pkg.sv
// constants shared by the serial eeprom command and status block
package eesr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // opcodes, compared after masking out the don't-care bit 3
   localparam logic [7:0] OPC_MASK = 8'hF7;
   localparam logic [7:0] OPC_UPPER_MASK = 8'hF0;
   localparam logic [7:0] OPC_SET_LATCH = 8'h06;
   localparam logic [7:0] OPC_CLEAR_LATCH = 8'h04;
   localparam logic [7:0] OPC_READ_STATE = 8'h05;
   localparam logic [7:0] OPC_WRITE_STATE = 8'h01;
   localparam logic [7:0] OPC_READ_ARRAY = 8'h03;
   localparam logic [7:0] OPC_WRITE_ARRAY = 8'h02;

   ////////////////////////////////////////////////////////////////////////////
   // status register field positions
   localparam int ST_PROTECT_PIN_EN = 7;
   localparam int ST_RESERVED_HI = 6;
   localparam int ST_RESERVED_LO = 4;
   localparam int ST_GUARD_HI = 3;
   localparam int ST_GUARD_LO = 2;
   localparam int ST_WRITE_LATCH = 1;
   localparam int ST_BUSY = 0;

   // reset and factory values
   localparam logic PROTECT_PIN_EN_RST = 1'b0;
   localparam logic [1:0] BLOCK_GUARD_RST = 2'h0;
   localparam logic WRITE_LATCH_RST = 1'b0;
   localparam logic BUSY_RST = 1'b0;
   localparam logic [7:0] STATUS_SNAP_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // serial framing
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // self-timed write cycle, longest time rounded down
   localparam int WRITE_CYCLE_US = 5000;
   localparam int SYS_CLK_MHZ = 125;
   localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_US * SYS_CLK_MHZ;
   localparam int WC_CNT_W = 20;

   ////////////////////////////////////////////////////////////////////////////
   // receive phase of a frame
   typedef enum logic [2:0] {
      EESR_RX_OPCODE = 3'b001,
      EESR_RX_DATA = 3'b010,
      EESR_RX_IGNORE = 3'b100
   } eesr_rx_t;

endpackage : eesr_pkg

// ===== eesr_sync.sv
// two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module eesr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end

endmodule : eesr_sync

// ===== eesr_command_status.sv
// serial eeprom instruction decoder, status register and status read
//
// What this block does
// - first byte after select lands in an 8-bit instruction register as opcode
// - all bytes travel MSb first; every command starts at a select falling edge
// - decode 0000x110 set latch, 0000x100 clear latch, 0000x101 read status
// - decode 0000x001 write status, 0000x011 array read, 0000x010 array write
// - status: bit7 pin enable, 6:4 reserved, 3:2 guard, 1 latch, 0 busy
// - reserved bits read zero when idle, ones during a write cycle
// - guard bits 00 none, 01 quarter, 10 half, 11 all; 00 factory value
// - busy reads 1 during an internal operation, 0 when ready
// - latch not writable by status write, reads 1 when enabled, 0 at power-up
// - after opcode 05h the full status byte shifts out on the serial output
// - opcode 06h then select released sets the write latch
// - opcode 04h clears the write latch, disabling programming
// - latch clear ignores the protect pin level
// - unknown opcode: accept nothing more, output floats until next select
// - while deselected ignore serial input, serial output floats
// - sample on rising clock, change output on falling; idle low or high
// - status write alters only bits 7, 3 and 2
`timescale 1ns/1ps
module eesr_command_status #(
   parameter int WC_CYCLES = eesr_pkg::WRITE_CYCLE_CYC
) (
   // system clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // serial link from the master
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   output logic spi_so,
   output logic spi_so_oe,
   // write protect pin
   input wire logic wp_n,
   // status view
   output logic protect_pin_enable,
   output logic [1:0] block_guard,
   output logic write_latch,
   output logic busy_flag
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   // link side
   eesr_pkg::eesr_rx_t rx_state;
   logic [2:0] bit_cnt;
   logic [6:0] rx_shift;
   logic [7:0] next_byte;
   logic [7:0] cmd_op;
   logic [7:0] cmd_data;
   logic cmd_tog;
   logic rd_active;
   logic [2:0] tx_idx;
   logic [7:0] masked_byte;

   // system side
   logic cs_s;
   logic wp_s;
   logic tog_s;
   logic cs_q;
   logic tog_q;
   logic wp_q;
   logic cs_rise;
   logic tog_evt;
   logic pend;
   logic exec;
   logic [7:0] exec_op;
   logic wp_dropped;
   logic hw_protect;
   logic do_set;
   logic do_clear;
   logic do_write_state;
   logic [eesr_pkg::WC_CNT_W-1:0] wc_cnt;
   logic wc_done;
   logic [7:0] status_view;
   logic [7:0] status_snap;

   ////////////////////////////////////////////////////////////////////////////
   // opcode classification

   function automatic logic opcode_known(input logic [7:0] b);
      logic [7:0] m;
      m = b & eesr_pkg::OPC_MASK;
      opcode_known = 1'b0;
      if ((b & eesr_pkg::OPC_UPPER_MASK) == 8'h00)
      begin
         case (m)
            eesr_pkg::OPC_SET_LATCH,
            eesr_pkg::OPC_CLEAR_LATCH,
            eesr_pkg::OPC_READ_STATE,
            eesr_pkg::OPC_WRITE_STATE,
            eesr_pkg::OPC_READ_ARRAY,
            eesr_pkg::OPC_WRITE_ARRAY: opcode_known = 1'b1;
            default: opcode_known = 1'b0;
         endcase
      end
   endfunction : opcode_known

   // MSb first: the newest bit enters at the bottom
   assign next_byte = {rx_shift, spi_si};
   assign masked_byte = next_byte & eesr_pkg::OPC_MASK;

   ////////////////////////////////////////////////////////////////////////////
   // link: receive on rising serial clock, frame state cleared by deselect

   // deselect acts as asynchronous reset, so any frame restarts cleanly
   always_ff @(posedge spi_sck or posedge spi_cs_n)
   begin
      if (spi_cs_n)
      begin
         rx_state <= eesr_pkg::EESR_RX_OPCODE;
         bit_cnt <= eesr_pkg::BIT_FIRST;
         rx_shift <= 7'h00;
      end
      else
      begin
         case (rx_state)
            eesr_pkg::EESR_RX_OPCODE:
            begin
               rx_shift <= next_byte[6:0];
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == eesr_pkg::BIT_LAST)
               begin
                  if (opcode_known(next_byte) &&
                      masked_byte == eesr_pkg::OPC_WRITE_STATE)
                  begin
                     rx_state <= eesr_pkg::EESR_RX_DATA;
                  end
                  else
                  begin
                     // unknown and byte-only opcodes take nothing more
                     rx_state <= eesr_pkg::EESR_RX_IGNORE;
                  end
               end
            end
            eesr_pkg::EESR_RX_DATA:
            begin
               rx_shift <= next_byte[6:0];
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == eesr_pkg::BIT_LAST)
               begin
                  rx_state <= eesr_pkg::EESR_RX_IGNORE;
               end
            end
            eesr_pkg::EESR_RX_IGNORE:
            begin
               rx_state <= eesr_pkg::EESR_RX_IGNORE;
            end
            default:
            begin
               rx_state <= eesr_pkg::EESR_RX_IGNORE;
            end
         endcase
      end
   end

   // status read is armed by the eighth rising edge
   always_ff @(posedge spi_sck or posedge spi_cs_n)
   begin
      if (spi_cs_n)
      begin
         rd_active <= 1'b0;
      end
      else if (rx_state == eesr_pkg::EESR_RX_OPCODE && bit_cnt == eesr_pkg::BIT_LAST)
      begin
         rd_active <= opcode_known(next_byte) &&
                      masked_byte == eesr_pkg::OPC_READ_STATE;
      end
   end

   // instruction and data words survive deselect so the system side can
   // read them after the select rise; the toggle announces a finished command
   always_ff @(posedge spi_sck or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cmd_op <= 8'h00;
         cmd_data <= 8'h00;
         cmd_tog <= 1'b0;
      end
      else if (!spi_cs_n)
      begin
         if (rx_state == eesr_pkg::EESR_RX_OPCODE && bit_cnt == eesr_pkg::BIT_LAST)
         begin
            cmd_op <= next_byte;
            if (opcode_known(next_byte) &&
                (masked_byte == eesr_pkg::OPC_SET_LATCH ||
                 masked_byte == eesr_pkg::OPC_CLEAR_LATCH))
            begin
               cmd_tog <= ~cmd_tog;
            end
         end
         else if (rx_state == eesr_pkg::EESR_RX_DATA && bit_cnt == eesr_pkg::BIT_LAST)
         begin
            cmd_data <= next_byte;
            cmd_tog <= ~cmd_tog;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link: transmit on falling serial clock

   // status_snap is frozen while selected, so it is stable here;
   // the byte repeats for as long as the master keeps clocking
   always_ff @(negedge spi_sck or posedge spi_cs_n)
   begin
      if (spi_cs_n)
      begin
         spi_so <= 1'b0;
         spi_so_oe <= 1'b0;
         tx_idx <= eesr_pkg::BIT_LAST;
      end
      else if (rd_active)
      begin
         spi_so_oe <= 1'b1;
         spi_so <= status_snap[tx_idx];
         tx_idx <= tx_idx - 3'h1;
      end
      else
      begin
         spi_so_oe <= 1'b0;
         spi_so <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // crossing into the system clock

   eesr_sync #(
      .W(3),
      .RST_VAL(3'b110)
   ) u_sync (
      .clk(clk_sys),
      .rst(sys_rst),
      .d({spi_cs_n, wp_n, cmd_tog}),
      .q({cs_s, wp_s, tog_s})
   );

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cs_q <= 1'b1;
         tog_q <= 1'b0;
         wp_q <= 1'b1;
      end
      else
      begin
         cs_q <= cs_s;
         tog_q <= tog_s;
         wp_q <= wp_s;
      end
   end

   assign cs_rise = cs_s & ~cs_q;
   assign tog_evt = tog_s ^ tog_q;

   // a toggle landing in the same cycle as the select rise is still executed
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pend <= 1'b0;
      end
      else if (cs_rise)
      begin
         pend <= 1'b0;
      end
      else if (tog_evt)
      begin
         pend <= 1'b1;
      end
   end

   // commands act only once the master releases select
   assign exec = cs_rise & (pend | tog_evt);
   assign exec_op = cmd_op & eesr_pkg::OPC_MASK;

   // protect pin falling inside a frame spoils a pending status write
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wp_dropped <= 1'b0;
      end
      else if (!cs_s && wp_q && !wp_s)
      begin
         // a drop in the select-fall cycle must not be lost, so set wins
         wp_dropped <= 1'b1;
      end
      else if (!cs_s && cs_q)
      begin
         wp_dropped <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command execution

   assign hw_protect = protect_pin_enable & (~wp_s | wp_dropped);
   // while busy only the status read is honoured, and that never executes here
   assign do_set = exec & ~busy_flag & (exec_op == eesr_pkg::OPC_SET_LATCH);
   assign do_clear = exec & ~busy_flag & (exec_op == eesr_pkg::OPC_CLEAR_LATCH);
   assign do_write_state = exec & ~busy_flag & write_latch & ~hw_protect &
                           (exec_op == eesr_pkg::OPC_WRITE_STATE);
   assign wc_done = busy_flag & (wc_cnt == '0);

   // write latch: never loaded from the data byte
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         write_latch <= eesr_pkg::WRITE_LATCH_RST;
      end
      else if (do_set)
      begin
         write_latch <= 1'b1;
      end
      else if (do_clear)
      begin
         // no protect pin term on purpose
         write_latch <= 1'b0;
      end
      else if (wc_done)
      begin
         write_latch <= 1'b0;
      end
   end

   // nonvolatile bits: reset stands in for the factory state
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         protect_pin_enable <= eesr_pkg::PROTECT_PIN_EN_RST;
         block_guard <= eesr_pkg::BLOCK_GUARD_RST;
      end
      else if (do_write_state)
      begin
         protect_pin_enable <= cmd_data[eesr_pkg::ST_PROTECT_PIN_EN];
         block_guard <= cmd_data[eesr_pkg::ST_GUARD_HI:eesr_pkg::ST_GUARD_LO];
      end
   end

   // self-timed write cycle
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy_flag <= eesr_pkg::BUSY_RST;
         wc_cnt <= '0;
      end
      else if (do_write_state)
      begin
         busy_flag <= 1'b1;
         wc_cnt <= eesr_pkg::WC_CNT_W'(WC_CYCLES - 1);
      end
      else if (wc_done)
      begin
         busy_flag <= 1'b0;
      end
      else if (busy_flag)
      begin
         wc_cnt <= wc_cnt - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status byte as seen by the master

   always_comb
   begin
      status_view = 8'h00;
      status_view[eesr_pkg::ST_PROTECT_PIN_EN] = protect_pin_enable;
      status_view[eesr_pkg::ST_RESERVED_HI:eesr_pkg::ST_RESERVED_LO] =
         {3{busy_flag}};
      status_view[eesr_pkg::ST_GUARD_HI:eesr_pkg::ST_GUARD_LO] = block_guard;
      status_view[eesr_pkg::ST_WRITE_LATCH] = write_latch;
      status_view[eesr_pkg::ST_BUSY] = busy_flag;
   end

   // snapshot only moves while deselected, giving the link a steady word;
   // the price is that busy ending mid-frame shows in the next frame
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         status_snap <= eesr_pkg::STATUS_SNAP_RST;
      end
      else if (cs_s && cs_q)
      begin
         status_snap <= status_view;
      end
   end

endmodule : eesr_command_status

// ===== eesr_master.sv
// serial master model that frames commands in mode 0 or mode 3
`timescale 1ns/1ps
module eesr_master (
   // link pins
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_si,
   input wire logic spi_so,
   input wire logic spi_so_oe
);
   // idle level of the clock: 0 for mode 0, 1 for mode 3
   logic cpol;
   // nothing pulls a released line; spi_so is held low then, so the model reads it as 1
   logic so_line;
   assign so_line = spi_so_oe ? spi_so : ~spi_so;
   initial
   begin
      cpol = 1'b0;
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // moves the idle clock level while deselected
   task set_idle(input logic pol);
      cpol = pol;
      spi_sck = pol;
      #64;
   endtask : set_idle
   // clock stands at its idle level between frames; si flips once released
   task frame(input logic [15:0] bits, input int n, output logic [7:0] rd,
      output logic oe_any);
      rd = 8'h00;
      oe_any = 1'b0;
      // 3 ns off the system clock edges; later steps are whole periods, so the phase stays fixed
      #3 spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         #24 spi_sck = 1'b0;
         spi_si = bits[15 - i];
         #24 spi_sck = 1'b1;
         if (i >= 8) rd = {rd[6:0], so_line};
         oe_any = oe_any | spi_so_oe;
      end
      #24 spi_sck = cpol;
      #24 spi_cs_n = 1'b1;
      spi_si = ~spi_si;
      #64;
   endtask : frame
endmodule : eesr_master

// ===== eesr_command_status_sva.sv
// port assertions for the command and status block
`timescale 1ns/1ps
module eesr_command_status_sva #(
   parameter int WC_CYCLES = 50
) (
   // system clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // serial link
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic spi_so,
   input wire logic spi_so_oe,
   // write protect pin
   input wire logic wp_n,
   // status view
   input wire logic protect_pin_enable,
   input wire logic [1:0] block_guard,
   input wire logic write_latch,
   input wire logic busy_flag
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic [19:0] busy_cnt;
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         busy_cnt <= 20'h00000;
      else if (busy_flag)
         busy_cnt <= busy_cnt + 20'h00001;
      else
         busy_cnt <= 20'h00000;
   end
   ////////////////////////////////////////////////////////////////////////////
   oe_idle_a: assert property (spi_cs_n && $past(spi_cs_n) |-> !spi_so_oe)
      else $error("output enabled while deselected");
   so_quiet_a: assert property (!spi_so_oe |-> !spi_so)
      else $error("serial output driven while disabled");
   oe_hold_a: assert property (spi_so_oe && !spi_cs_n |=> spi_so_oe || spi_cs_n)
      else $error("output enable dropped inside frame");
   busy_len_a: assert property ($fell(busy_flag) |-> busy_cnt == WC_CYCLES)
      else $error("write cycle length wrong");
   busy_max_a: assert property (busy_flag |-> busy_cnt < WC_CYCLES)
      else $error("write cycle overran");
   end_clear_a: assert property ($fell(busy_flag) |-> ##[0:1] !write_latch)
      else $error("latch kept after write cycle");
   guard_write_a: assert property (
      $changed({protect_pin_enable, block_guard}) |-> $rose(busy_flag))
      else $error("guard bits changed outside a write");
   write_gate_a: assert property ($rose(busy_flag) |-> $past(write_latch))
      else $error("write started without latch");
   set_idle_a: assert property (
      $rose(write_latch) |-> spi_cs_n && !$past(busy_flag))
      else $error("latch set in frame or while busy");
   rst_clear_a: assert property (
      $fell(sys_rst) |-> !write_latch && !busy_flag && block_guard == 2'h0)
      else $error("status not cleared by reset");
   cover property ($rose(busy_flag));
   cover property ($fell(busy_flag));
   cover property ($rose(spi_so_oe));
   cover property ($rose(write_latch));
endmodule : eesr_command_status_sva

bind eesr_command_status eesr_command_status_sva #(.WC_CYCLES(WC_CYCLES))
   u_eesr_command_status_sva (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
   .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .wp_n(wp_n),
   .protect_pin_enable(protect_pin_enable), .block_guard(block_guard),
   .write_latch(write_latch), .busy_flag(busy_flag));

// ===== eesr_command_status_bench.sv
// self-checking bench for the command and status block
`timescale 1ns/1ps
module eesr_command_status_bench;
   localparam int WC = 400;
   localparam logic [7:0] LOPS [4] = '{8'h06, 8'h04, 8'h0E, 8'h0C};
   localparam logic [7:0] LEXP [4] = '{8'h01, 8'h00, 8'h01, 8'h00};
   localparam logic [7:0] LBAD [5] = '{8'h10, 8'h00, 8'h07, 8'hF5, 8'h8D};
   localparam logic [7:0] LDAT [4] = '{8'hF7, 8'h4A, 8'h3D, 8'h72};
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic wp_n = 1'b1;
   logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, oe;
   logic protect_pin_enable, write_latch, busy_flag;
   logic [1:0] block_guard;
   logic [7:0] rd, view;
   int err_total = 0;
   int checks_done = 0;
   assign view = {protect_pin_enable, 3'h0, block_guard, write_latch, busy_flag};
   always #4 clk_sys = ~clk_sys;
   eesr_command_status #(.WC_CYCLES(WC)) u_eesr_command_status (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .spi_so(spi_so), .spi_so_oe(spi_so_oe), .wp_n(wp_n),
      .protect_pin_enable(protect_pin_enable), .block_guard(block_guard),
      .write_latch(write_latch), .busy_flag(busy_flag));
   eesr_master u_eesr_master (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .spi_so(spi_so), .spi_so_oe(spi_so_oe));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task gap(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : gap
   task cmd(input logic [7:0] op);
      u_eesr_master.frame({op, 8'h00}, 8, rd, oe);
      gap(6);
   endtask : cmd
   task wrst(input logic [7:0] d);
      u_eesr_master.frame({eesr_pkg::OPC_WRITE_STATE, d}, 16, rd, oe);
      gap(6);
   endtask : wrst
   task rdst(input logic [7:0] op, input logic [7:0] exp);
      u_eesr_master.frame({op, 8'h00}, 16, rd, oe);
      chk("status read", exp, rd);
      gap(6);
   endtask : rdst
   task final_report();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////////
   // whole run is near 50 us; allow ample margin
   initial
   begin
      #200000;
      err_total++;
      final_report();
   end
   initial
   begin
      gap(5);
      sys_rst = 1'b0;
      gap(4);
      chk("view", 8'h00, view);
      rdst(8'h05, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         // clears are sent with the protect pin low
         wp_n = LEXP[i][0];
         cmd(LOPS[i]);
         chk("latch", LEXP[i], {7'h00, write_latch});
      end
      wp_n = 1'b1;
      cmd(8'h06);
      rdst(8'h0D, 8'h02);
      u_eesr_master.frame({8'h04, 8'h00}, 5, rd, oe);
      gap(6);
      chk("partial", 8'h01, {7'h00, write_latch});
      for (int i = 0; i < 5; i++)
      begin
         u_eesr_master.frame({LBAD[i], 8'h00}, 16, rd, oe);
         chk("invalid oe", 8'h00, {7'h00, oe});
      end
      // clear pattern behind a nonzero upper nibble must not act
      cmd(8'h14);
      chk("bad clear", 8'h01, {7'h00, write_latch});
      $display("test commands done");
      cmd(8'h04);
      wrst(8'h8C);
      chk("no latch", 8'h00, view);
      cmd(8'h06);
      wrst(8'hFF);
      chk("busy view", 8'h8F, view);
      rdst(8'h05, 8'hFF);
      cmd(8'h04);
      chk("busy ignore", 8'h8F, view);
      gap(WC + 10);
      chk("idle view", 8'h8C, view);
      rdst(8'h05, 8'h8C);
      $display("test write cycle done");
      wp_n = 1'b0;
      gap(4);
      cmd(8'h06);
      wrst(8'h00);
      gap(WC);
      chk("protected", 8'h8E, view);
      // pin low and pin enable set: the clear must still act
      cmd(8'h04);
      chk("clear protected", 8'h8C, view);
      wp_n = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         cmd(8'h06);
         wrst(LDAT[i]);
         gap(WC + 10);
         chk("guard", LDAT[i] & 8'h8C, view);
      end
      $display("test guard codes done");
      u_eesr_master.set_idle(1'b1);
      cmd(8'h06);
      rdst(8'h05, 8'h02);
      cmd(8'h04);
      chk("mode 3 clear", 8'h00, view);
      u_eesr_master.set_idle(1'b0);
      $display("test clock mode 3 done");
      final_report();
   end
endmodule : eesr_command_status_bench
